/* File: inc/rfsm_pkg.sv */
// Package for the reference failure status and mask register block.
// Assumes a 16-bit register view on a 32-bit Avalon-MM word bus.
package rfsm_pkg;
  localparam int unsigned RFSM_NUM_REFS = 4;
  localparam int unsigned RFSM_CHECKS = 4;
  localparam int unsigned RFSM_REG_W = 16;
  localparam int unsigned RFSM_ADDR_W = 10;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] RFSM_IDX_STATUS = 8'h69;
  localparam logic [7:0] RFSM_IDX_MASK = 8'h6A;
  localparam logic [9:0] RFSM_ADDR_STATUS = {RFSM_IDX_STATUS, 2'b00};
  localparam logic [9:0] RFSM_ADDR_MASK = {RFSM_IDX_MASK, 2'b00};
  // Field positions inside one reference nibble
  localparam int unsigned RFSM_BIT_SINGLE_UPPER = 0;
  localparam int unsigned RFSM_BIT_SINGLE_LOWER = 1;
  localparam int unsigned RFSM_BIT_MULTI_UPPER = 2;
  localparam int unsigned RFSM_BIT_MULTI_LOWER = 3;
  localparam logic [15:0] RFSM_MASK_RESET = 16'h0000;
  localparam logic [15:0] RFSM_STATUS_RESET = 16'h0000;
  localparam logic [31:0] RFSM_UNMAPPED_DATA = 32'h00000000;
  typedef enum logic [1:0] {RFSM_IDLE, RFSM_ANSWER} rfsm_bus_state_t;
endpackage

/* File: inc/rfsm_check_if.sv */
// Interface carrying raw check results and masks between the register
// block and its per-reference masking stage. Same clock domain throughout.
`timescale 1ns/100ps
interface rfsm_check_if;
  logic [15:0] raw_fail;
  logic [15:0] mask;
  logic [15:0] masked_fail;
  modport regs (output raw_fail, output mask, input masked_fail);
  modport gate (input raw_fail, input mask, output masked_fail);
endinterface

/* File: logic/rfsm_mask_gate.sv */
// Masking stage: one nibble of checks per reference, a set mask bit forces pass.
// Assumes raw results are already synchronised to mclk.
`timescale 1ns/100ps
module rfsm_mask_gate
(
  rfsm_check_if.gate chk
);
  genvar g;
  // One generate per check bit keeps the nibble layout uniform across references
  generate
    for (g = 0; g < 16; g++)
    begin : g_bit
      assign chk.masked_fail[g] = chk.raw_fail[g] & ~chk.mask[g];
    end
  endgenerate
endmodule // rfsm_mask_gate

/* File: logic/rfsm_regs.sv */
// Reference failure status and check mask registers on Avalon-MM.
// Holds the two-stage input synchroniser, the live status view, the mask
// register with byte-lane writes and a one-wait-state bus slave.
// Assumes raw check results come from period monitors outside mclk's control,
// so they are synchronised here before use.
// Assumes one master that holds each request until it sees waitrequest low.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
module rfsm_regs
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] ref_single_upper_fail,
  input wire logic [3:0] ref_single_lower_fail,
  input wire logic [3:0] ref_multi_upper_fail,
  input wire logic [3:0] ref_multi_lower_fail,
  output logic [15:0] reference_check_mask
);
  rfsm_check_if chk ();

  // Synchroniser, status, mask and bus answer state
  logic [15:0] sync1_reg, sync1_next;
  logic [15:0] sync2_reg, sync2_next;
  logic [15:0] status_reg, status_next;
  logic [15:0] mask_reg, mask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;
  rfsm_pkg::rfsm_bus_state_t state_reg, state_next;
  logic [15:0] raw_pack;

  // Bus decode terms shared by the answer group and the mask group
  logic take_req;
  logic hit_status;
  logic hit_mask;
  logic mask_write;

  // Mask value after the enabled byte lanes of the write data are applied
  logic [15:0] lane_merge;
  genvar lane;

  // Arrange the four check results of each reference into its own nibble
  always_comb
  begin
    raw_pack = 16'h0000;
    for (int r = 0; r < 4; r++)
    begin
      raw_pack[4*r + rfsm_pkg::RFSM_BIT_SINGLE_UPPER] = ref_single_upper_fail[r];
      raw_pack[4*r + rfsm_pkg::RFSM_BIT_SINGLE_LOWER] = ref_single_lower_fail[r];
      raw_pack[4*r + rfsm_pkg::RFSM_BIT_MULTI_UPPER] = ref_multi_upper_fail[r];
      raw_pack[4*r + rfsm_pkg::RFSM_BIT_MULTI_LOWER] = ref_multi_lower_fail[r];
    end
  end

  assign chk.raw_fail = sync2_reg;
  assign chk.mask = mask_reg;

  // Mask stage forces each masked check to pass.
  // The raw result is left untouched, so clearing a mask bit shows it again.
  rfsm_mask_gate rfsm_mask_gate_inst
  (
    .chk(chk.gate)
  );

  // Two-stage synchroniser; first stage feeds only the second
  always_comb
  begin
    sync1_next = raw_pack;
    sync2_next = sync1_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sync1_reg <= rfsm_pkg::RFSM_STATUS_RESET;
      sync2_reg <= rfsm_pkg::RFSM_STATUS_RESET;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // Status is a live view of the masked result, never latched.
  // A check that passes again drops its bit three edges later, through the synchroniser; a masked one drops it on the edge after the mask changes.
  always_comb
  begin
    status_next = chk.masked_fail;
  end

  // Status register; reads see it one cycle after the mask stage
  // because the bus answer is taken from this flop, not from the gate
  always_ff @(posedge mclk)
  begin
    if (reset)
      status_reg <= rfsm_pkg::RFSM_STATUS_RESET;
    else
      status_reg <= status_next;
  end

  // Address decode. Only the idle state takes a request, so a request that
  // is still held during the answer cycle is never taken a second time.
  always_comb
  begin
    take_req = (avs_read || avs_write) && (state_reg == rfsm_pkg::RFSM_IDLE);
    hit_status = (avs_address == rfsm_pkg::RFSM_ADDR_STATUS);
    hit_mask = (avs_address == rfsm_pkg::RFSM_ADDR_MASK);
    // The write lands on the answer edge, the one edge the master counts
    mask_write = (state_reg == rfsm_pkg::RFSM_ANSWER) && avs_write && hit_mask;
  end

  // Byte lanes 0 and 1 cover the 16-bit mask; lanes 2 and 3 have no storage
  // behind them and are dropped without an error response
  generate
    for (lane = 0; lane < 2; lane++)
    begin : g_lane
      assign lane_merge[8*lane +: 8] = avs_byteenable[lane] ? avs_writedata[8*lane +: 8]
        : mask_reg[8*lane +: 8];
    end
  endgenerate

  // Mask register group. Writes to the status offset land nowhere, since
  // status is read-only; they are still answered so the master never hangs.
  always_comb
  begin
    mask_next = mask_reg;
    if (mask_write)
      mask_next = lane_merge;
  end

  // Mask register; resets to all checks live
  always_ff @(posedge mclk)
  begin
    if (reset)
      mask_reg <= rfsm_pkg::RFSM_MASK_RESET;
    else
      mask_reg <= mask_next;
  end

  // Bus slave: one wait cycle, then answer with waitrequest low.
  // The extra cycle lets readdata come from a flop without a combinational path.
  // Unmapped reads answer zero rather than stall, at the cost of no error flag.
  always_comb
  begin
    state_next = state_reg;
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    case (state_reg)
      rfsm_pkg::RFSM_IDLE:
      begin
        if (take_req)
        begin
          state_next = rfsm_pkg::RFSM_ANSWER;
          wait_next = 1'b0;
          rdata_next = rfsm_pkg::RFSM_UNMAPPED_DATA;
          if (avs_read && hit_status)
            rdata_next = {16'h0000, status_reg};
          else if (avs_read && hit_mask)
            rdata_next = {16'h0000, mask_reg};
        end
      end
      rfsm_pkg::RFSM_ANSWER:
      begin
        // Back to rest; the master releases its request on this edge
        state_next = rfsm_pkg::RFSM_IDLE;
        wait_next = 1'b1;
      end
      default:
      begin
        state_next = rfsm_pkg::RFSM_IDLE;
      end
    endcase
  end

  // Bus answer registers; waitrequest rests high so an early request waits
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_reg <= rfsm_pkg::RFSM_IDLE;
      wait_reg <= 1'b1;
      rdata_reg <= rfsm_pkg::RFSM_UNMAPPED_DATA;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // Outputs come straight from registers, with no logic after the flops
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign reference_check_mask = mask_reg;
endmodule // rfsm_regs

/* File: verification/rfsm_regs_props.sv */
// Checker for the reference status and mask register block.
// Sees only the ports of rfsm_regs; one clock domain.
`timescale 1ns/100ps
module rfsm_regs_props
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [3:0] ref_single_upper_fail,
  input wire logic [3:0] ref_single_lower_fail,
  input wire logic [3:0] ref_multi_upper_fail,
  input wire logic [3:0] ref_multi_lower_fail,
  input wire logic [15:0] reference_check_mask
);
  logic [15:0] raw;
  logic [31:0] prev_reg;
  logic [3:0] quiet_reg;
  logic [15:0] wr_lo;
  // Low half of the write data, the part the mask register keeps
  assign wr_lo = avs_writedata[15:0];
  // Raw checks in status layout, one nibble per reference
  always_comb
  begin
    for (int r = 0; r < 4; r++)
      raw[4*r +: 4] = {ref_multi_lower_fail[r], ref_multi_upper_fail[r],
        ref_single_lower_fail[r], ref_single_upper_fail[r]};
  end
  // Quiet count: status is only judged once the sync pipe has settled
  always_ff @(posedge mclk)
  begin
    prev_reg <= {raw, reference_check_mask};
    quiet_reg <= (reset || prev_reg != {raw, reference_check_mask}) ? 4'h0
      : quiet_reg + {3'h0, ~&quiet_reg};
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_rd; !avs_waitrequest && avs_read; endsequence
  property p_ans; s_req |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
  property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
  property p_mrst; $fell(reset) |-> reference_check_mask == 16'h0000; endproperty
  property p_mwr; !avs_waitrequest && avs_write && avs_address == 10'h1A8
    && avs_byteenable == 4'hF |=> reference_check_mask == $past(wr_lo); endproperty
  property p_ro; avs_write && avs_address == 10'h1A4 |=> $stable(reference_check_mask);
  endproperty
  property p_rmask; s_rd ##0 avs_address == 10'h1A8
    |-> avs_readdata == {16'h0000, reference_check_mask}; endproperty
  property p_unmap; s_rd ##0 avs_address != 10'h1A4 && avs_address != 10'h1A8
    |-> avs_readdata == 32'h00000000; endproperty
  property p_stat; s_rd ##0 avs_address == 10'h1A4 && quiet_reg > 4'h2
    |-> avs_readdata == {16'h0000, raw & ~reference_check_mask}; endproperty
  a_ans: assert property (p_ans) else $error("answer timing");
  a_idle: assert property (p_idle) else $error("idle answer");
  a_mrst: assert property (p_mrst) else $error("mask reset");
  a_mwr: assert property (p_mwr) else $error("mask write");
  a_ro: assert property (p_ro) else $error("status write");
  a_rmask: assert property (p_rmask) else $error("mask read");
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  a_stat: assert property (p_stat) else $error("status read");
endmodule // rfsm_regs_props
bind rfsm_regs rfsm_regs_props rfsm_regs_props_inst
(
  .mclk(mclk),
  .reset(reset),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .ref_single_upper_fail(ref_single_upper_fail),
  .ref_single_lower_fail(ref_single_lower_fail),
  .ref_multi_upper_fail(ref_multi_upper_fail),
  .ref_multi_lower_fail(ref_multi_lower_fail),
  .reference_check_mask(reference_check_mask)
);

/* File: verification/rfsm_regs_tb_top.sv */
// Testbench for the reference status and mask register block.
// Drives the Avalon-MM port and raw check inputs directly.
`timescale 1ns/100ps
module rfsm_regs_tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [15:0] raw = 16'h0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] reference_check_mask;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  always #25 mclk = ~mclk;
  rfsm_regs rfsm_regs_inst
  (
    .mclk(mclk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ref_single_upper_fail({raw[12], raw[8], raw[4], raw[0]}),
    .ref_single_lower_fail({raw[13], raw[9], raw[5], raw[1]}),
    .ref_multi_upper_fail({raw[14], raw[10], raw[6], raw[2]}),
    .ref_multi_lower_fail({raw[15], raw[11], raw[7], raw[3]}),
    .reference_check_mask(reference_check_mask)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Request held until waitrequest is seen low; the slave sets the pace
  task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d,
    input logic [3:0] be, input logic [31:0] e);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    if (!w) chk(avs_readdata, e);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 1500)
    begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    acc(1'b0, 10'h1A8, 32'h0, 4'hF, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      raw <= 16'h0001 << i;
      repeat (6) @(posedge mclk);
      acc(1'b0, 10'h1A4, 32'h0, 4'hF, {16'h0000, 16'h0001 << i});
    end
    raw <= 16'hFFFF;
    // Each mask bit alone clears only its own status bit
    for (int i = 0; i < 16; i++)
    begin
      acc(1'b1, 10'h1A8, {16'h0000, 16'h0001 << i}, 4'hF, 32'h0);
      chk({16'h0000, reference_check_mask}, {16'h0000, 16'h0001 << i});
      acc(1'b0, 10'h1A8, 32'h0, 4'hF, {16'h0000, 16'h0001 << i});
      acc(1'b0, 10'h1A4, 32'h0, 4'hF, {16'h0000, ~(16'h0001 << i)});
    end
    acc(1'b1, 10'h1A8, 32'h0, 4'hF, 32'h0);
    acc(1'b0, 10'h1A4, 32'h0, 4'hF, 32'h0000FFFF);
    raw <= 16'h0000;
    repeat (6) @(posedge mclk);
    acc(1'b0, 10'h1A4, 32'h0, 4'hF, 32'h0);
    acc(1'b1, 10'h1A4, 32'h0000AAAA, 4'hF, 32'h0);
    acc(1'b1, 10'h1A8, 32'h0000AAAA, 4'h3, 32'h0);
    acc(1'b1, 10'h1A8, 32'h00005555, 4'h1, 32'h0);
    acc(1'b0, 10'h1A8, 32'h0, 4'hF, 32'h0000AA55);
    chk({16'h0000, reference_check_mask}, 32'h0000AA55);
    acc(1'b0, 10'h000, 32'h0, 4'hF, 32'h0);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    chk({16'h0000, reference_check_mask}, 32'h0);
    acc(1'b0, 10'h1A8, 32'h0, 4'hF, 32'h0);
    tally_and_finish;
  end
endmodule // rfsm_regs_tb_top
